// *** hw/acs_pkg.sv ***
package acs_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int CYC_W = 22;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int WORD_W = 16;

  // ------------------------------------------------------------
  // calibration and timing counts in master-clock cycles
  // ------------------------------------------------------------
  localparam int SELF_CYC = 32'h002FFFB7;     // 3,145,655
  localparam int SYS_OFS_CYC = 32'h00100FB7;  // 1,052,599
  localparam int SYS_GAIN_CYC = 32'h00104F0D; // 1,068,813
  localparam int ONE_OFS_CYC = 32'h00204F0D;  // 2,117,389
  localparam int SETTLE_CYC = 32'h0007C000;   // 507,904 filter settling
  localparam int CORNER_DIV = 32'h00064000;   // 409,600
  localparam logic [7:0] SAMPLE_LAST = 8'hFF; // sample every 256 cycles
  localparam logic [2:0] STROBE_MIN = 3'h4;   // least strobe high time

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [AW-1:0] STAT_OFS = 8'h04;
  localparam logic [AW-1:0] COUNT_OFS = 8'h08;
  localparam logic [AW-1:0] REMAIN_OFS = 8'h0C;

  // control fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_SEL_LO = 1;
  localparam int CTRL_SEL_HI = 2;
  localparam int CTRL_BIPOLAR = 3;
  localparam int CTRL_OVR = 4;

  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_SEL_LO = 1;
  localparam int STAT_SEL_HI = 2;
  localparam int STAT_DONE = 3;
  localparam int STAT_BIPOLAR = 4;
  localparam int STAT_WORD_N = 5;
  localparam int STAT_REF_LO = 8;
  localparam int STAT_REF_HI = 10;

  // ------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CAL_SELF = 2'b00,
    CAL_GAIN2 = 2'b01,
    CAL_OFS1 = 2'b10,
    CAL_SYS1 = 2'b11
  } acs_cal_t; // index is {select_a, select_b}

  typedef enum logic [2:0] {
    REF_NONE = 3'h0,
    REF_ZERO_GND = 3'h1,
    REF_MID_GND = 3'h2,
    REF_ZERO_AIN = 3'h3,
    REF_FS_VREF = 3'h4,
    REF_FS_AIN = 3'h5
  } acs_ref_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CAL = 2'b01,
    ST_SETTLE = 2'b10
  } acs_state_t;

endpackage

// *** hw/acs_tmr_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface acs_tmr_if;
  logic load;
  logic [acs_pkg::CYC_W-1:0] load_val;
  logic [acs_pkg::CYC_W-1:0] remain;
  logic expire;
  modport ctl (output load, output load_val, input remain, input expire);
  modport tmr (input load, input load_val, output remain, output expire);
endinterface
`default_nettype wire

// *** hw/acs_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  // two-flop synchroniser, first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** hw/acs_cycle_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_cycle_timer (
  input wire logic clk,
  input wire logic rst_n,
  acs_tmr_if.tmr t
);
  // down counter, pulses expire on the step from one to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t.remain <= '0;
      t.expire <= 1'b0;
    end else if (t.load) begin
      t.remain <= t.load_val;
      t.expire <= 1'b0;
    end else begin
      t.expire <= (t.remain == acs_pkg::CYC_W'(1));
      if (t.remain != '0) begin
        t.remain <= t.remain - acs_pkg::CYC_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/acs_cal_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_cal_seq #(
  parameter int P_SELF = acs_pkg::SELF_CYC,
  parameter int P_SYS_OFS = acs_pkg::SYS_OFS_CYC,
  parameter int P_SYS_GAIN = acs_pkg::SYS_GAIN_CYC,
  parameter int P_ONE_OFS = acs_pkg::ONE_OFS_CYC,
  parameter int P_SETTLE = acs_pkg::SETTLE_CYC,
  parameter int P_CORNER = acs_pkg::CORNER_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acs_pkg::AW-1:0] paddr,
  input wire logic [acs_pkg::DW-1:0] pwdata,
  output logic [acs_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cal_strobe,
  input wire logic cal_type_select_a,
  input wire logic cal_type_select_b,
  input wire logic range_polarity_select,
  input wire logic [acs_pkg::WORD_W-1:0] raw_result,
  input wire logic raw_valid,
  output logic word_available_n,
  output logic [acs_pkg::WORD_W-1:0] data_word,
  output logic [2:0] ref_select,
  output logic cal_busy,
  output logic sample_tick,
  output logic corner_tick
);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [acs_pkg::CYC_W-1:0] cal_len(input logic [1:0] sel);
    case (sel)
      acs_pkg::CAL_SELF: cal_len = acs_pkg::CYC_W'(P_SELF);
      acs_pkg::CAL_SYS1: cal_len = acs_pkg::CYC_W'(P_SYS_OFS);
      acs_pkg::CAL_GAIN2: cal_len = acs_pkg::CYC_W'(P_SYS_GAIN);
      default: cal_len = acs_pkg::CYC_W'(P_ONE_OFS);
    endcase
  endfunction

  function automatic logic [2:0] ref_of(input logic [1:0] sel, input logic bip,
                                        input logic full);
    case (sel)
      acs_pkg::CAL_SELF: begin
        if (full) begin
          ref_of = acs_pkg::REF_FS_VREF;
        end else if (bip) begin
          ref_of = acs_pkg::REF_MID_GND;
        end else begin
          ref_of = acs_pkg::REF_ZERO_GND;
        end
      end
      acs_pkg::CAL_SYS1: ref_of = acs_pkg::REF_ZERO_AIN;
      acs_pkg::CAL_GAIN2: ref_of = acs_pkg::REF_FS_AIN;
      default: ref_of = full ? acs_pkg::REF_FS_VREF : acs_pkg::REF_ZERO_AIN;
    endcase
  endfunction

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [3:0] pins_s;
  logic strobe_s;
  logic [1:0] sel_s;
  logic pol_s;

  acs_sync #(.W(4)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din({cal_strobe, cal_type_select_a, cal_type_select_b, range_polarity_select}),
    .dout(pins_s)
  );

  assign strobe_s = pins_s[3];
  assign sel_s = pins_s[2:1];
  assign pol_s = pins_s[0];

  // ----------------------------------------------------------
  // cycle timer
  // ----------------------------------------------------------
  acs_tmr_if tif ();

  acs_cycle_timer u_tmr (
    .clk(pclk),
    .rst_n(presetn),
    .t(tif)
  );

  // ----------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------
  acs_pkg::acs_state_t state_r;
  logic strobe_d_r;
  logic [2:0] high_cnt_r;
  logic [1:0] cal_sel_r;
  logic [acs_pkg::CYC_W-1:0] half_r;
  logic ovr_r;
  logic ovr_bip_r;
  logic [1:0] sw_sel_r;
  logic go_r;
  logic done_r;
  logic calibrated_r;
  logic [15:0] cal_count_r;
  logic [7:0] samp_cnt_r;
  logic [acs_pkg::CYC_W-1:0] corner_cnt_r;
  logic pin_fall;
  logic start;
  logic bipolar;
  logic apb_wr;
  logic stat_clr;
  logic addr_ok;
  logic [acs_pkg::DW-1:0] rd_mux;

  assign bipolar = ovr_r ? ovr_bip_r : pol_s;
  // falling edge of a strobe that stood high long enough
  assign pin_fall = strobe_d_r && !strobe_s && (high_cnt_r >= acs_pkg::STROBE_MIN);
  assign start = (state_r == acs_pkg::ST_IDLE) && (pin_fall || go_r);

  // ----------------------------------------------------------
  // strobe edge detector and high-time counter
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_d_r <= 1'b0;
      high_cnt_r <= 3'h0;
    end else begin
      strobe_d_r <= strobe_s;
      if (!strobe_s) begin
        high_cnt_r <= 3'h0;
      end else if (high_cnt_r < acs_pkg::STROBE_MIN) begin
        high_cnt_r <= high_cnt_r + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------
  always_comb begin
    tif.load = 1'b0;
    tif.load_val = '0;
    if (start) begin
      tif.load = 1'b1;
      tif.load_val = cal_len(pin_fall ? sel_s : sw_sel_r);
    end else if (state_r == acs_pkg::ST_CAL && tif.expire) begin
      tif.load = 1'b1;
      tif.load_val = acs_pkg::CYC_W'(P_SETTLE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= acs_pkg::ST_IDLE;
      cal_sel_r <= 2'h0;
      half_r <= '0;
    end else begin
      case (state_r)
        acs_pkg::ST_IDLE: begin
          if (start) begin
            cal_sel_r <= pin_fall ? sel_s : sw_sel_r;
            half_r <= cal_len(pin_fall ? sel_s : sw_sel_r) >> 1;
            state_r <= acs_pkg::ST_CAL;
          end
        end
        acs_pkg::ST_CAL: begin
          if (tif.expire) begin
            state_r <= acs_pkg::ST_SETTLE;
          end
        end
        acs_pkg::ST_SETTLE: begin
          if (tif.expire) begin
            state_r <= acs_pkg::ST_IDLE;
          end
        end
        default: state_r <= acs_pkg::ST_IDLE;
      endcase
    end
  end

  // reference selection, zero half first then full half for self and one-step types, system types hold one reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_select <= acs_pkg::REF_NONE;
    end else if (state_r == acs_pkg::ST_CAL && !tif.expire) begin
      ref_select <= ref_of(cal_sel_r, bipolar, tif.remain <= half_r);
    end else begin
      ref_select <= acs_pkg::REF_NONE;
    end
  end

  // busy flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_busy <= 1'b0;
    end else begin
      cal_busy <= (state_r != acs_pkg::ST_IDLE) || start;
    end
  end

  // calibration bookkeeping; sticky done set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      calibrated_r <= 1'b0;
      cal_count_r <= 16'h0000;
    end else begin
      if (state_r == acs_pkg::ST_CAL && tif.expire) begin
        done_r <= 1'b1;
        calibrated_r <= 1'b1;
        cal_count_r <= cal_count_r + 16'h0001;
      end else if (stat_clr) begin
        done_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // output word and its ready flag
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_available_n <= 1'b1;
      data_word <= 16'h0000;
    end else if (start || state_r == acs_pkg::ST_CAL) begin
      word_available_n <= 1'b1;
    end else if (state_r == acs_pkg::ST_SETTLE) begin
      // self type waits for settling, others release at once
      word_available_n <= (cal_sel_r == acs_pkg::CAL_SELF) ? !tif.expire : 1'b0;
    end else if (raw_valid && calibrated_r) begin
      data_word <= bipolar ? (raw_result ^ 16'h8000) : raw_result;
      word_available_n <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // sampling and filter corner ticks
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_cnt_r <= 8'h00;
      sample_tick <= 1'b0;
    end else begin
      samp_cnt_r <= samp_cnt_r + 8'h01;
      sample_tick <= (samp_cnt_r == acs_pkg::SAMPLE_LAST);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corner_cnt_r <= '0;
      corner_tick <= 1'b0;
    end else if (corner_cnt_r == acs_pkg::CYC_W'(P_CORNER - 1)) begin
      corner_cnt_r <= '0;
      corner_tick <= 1'b1;
    end else begin
      corner_cnt_r <= corner_cnt_r + acs_pkg::CYC_W'(1);
      corner_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------
  assign apb_wr = psel && penable && pready && pwrite;
  assign stat_clr = apb_wr && (paddr == acs_pkg::STAT_OFS) && pwdata[acs_pkg::STAT_DONE];
  assign addr_ok = (paddr == acs_pkg::CTRL_OFS) || (paddr == acs_pkg::STAT_OFS) ||
                   (paddr == acs_pkg::COUNT_OFS) || (paddr == acs_pkg::REMAIN_OFS);

  // read multiplexer
  always_comb begin
    rd_mux = '0;
    case (paddr)
      acs_pkg::CTRL_OFS: begin
        rd_mux[acs_pkg::CTRL_SEL_HI:acs_pkg::CTRL_SEL_LO] = sw_sel_r;
        rd_mux[acs_pkg::CTRL_BIPOLAR] = ovr_bip_r;
        rd_mux[acs_pkg::CTRL_OVR] = ovr_r;
      end
      acs_pkg::STAT_OFS: begin
        rd_mux[acs_pkg::STAT_BUSY] = cal_busy;
        rd_mux[acs_pkg::STAT_SEL_HI:acs_pkg::STAT_SEL_LO] = cal_sel_r;
        rd_mux[acs_pkg::STAT_DONE] = done_r;
        rd_mux[acs_pkg::STAT_BIPOLAR] = bipolar;
        rd_mux[acs_pkg::STAT_WORD_N] = word_available_n;
        rd_mux[acs_pkg::STAT_REF_HI:acs_pkg::STAT_REF_LO] = ref_select;
      end
      acs_pkg::COUNT_OFS: rd_mux[15:0] = cal_count_r;
      acs_pkg::REMAIN_OFS: rd_mux[acs_pkg::CYC_W-1:0] = tif.remain;
      default: rd_mux = '0;
    endcase
  end

  // handshake and read data capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= rd_mux;
      pslverr <= !addr_ok;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // control register; go is a one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_sel_r <= 2'h0;
      ovr_r <= 1'b0;
      ovr_bip_r <= 1'b0;
      go_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      if (apb_wr && paddr == acs_pkg::CTRL_OFS) begin
        sw_sel_r <= pwdata[acs_pkg::CTRL_SEL_HI:acs_pkg::CTRL_SEL_LO];
        ovr_bip_r <= pwdata[acs_pkg::CTRL_BIPOLAR];
        ovr_r <= pwdata[acs_pkg::CTRL_OVR];
        go_r <= pwdata[acs_pkg::CTRL_GO];
      end
    end
  end

endmodule
`default_nettype wire

// *** verif/acs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host controller driving the calibration pins
// ------------------------------------------------------------
module acs_host_model (
  input wire logic pclk,
  output logic cal_strobe,
  output logic cal_type_select_a,
  output logic cal_type_select_b
);
  // pins idle low before the first pulse
  initial begin
    cal_strobe = 1'b0;
    cal_type_select_a = 1'b0;
    cal_type_select_b = 1'b0;
  end
  // strobe held for hold clocks, then the selects are scrambled once latched
  task automatic pulse(input logic [1:0] sel, input int hold);
    @(posedge pclk);
    cal_strobe <= 1'b1;
    {cal_type_select_a, cal_type_select_b} <= sel;
    repeat (hold) @(posedge pclk);
    cal_strobe <= 1'b0;
    fork
      begin
        repeat (6) @(posedge pclk);
        {cal_type_select_a, cal_type_select_b} <= ~sel;
      end
    join_none
  endtask
endmodule
`default_nettype wire

// *** verif/acs_cal_seq_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_cal_seq_properties #(
  parameter int P_SELF = 40,
  parameter int P_SYS_OFS = 20,
  parameter int P_SYS_GAIN = 20,
  parameter int P_ONE_OFS = 30,
  parameter int P_CORNER = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cal_strobe,
  input wire logic range_polarity_select,
  input wire logic [15:0] raw_result,
  input wire logic raw_valid,
  input wire logic word_available_n,
  input wire logic [15:0] data_word,
  input wire logic [2:0] ref_select,
  input wire logic cal_busy,
  input wire logic sample_tick,
  input wire logic corner_tick
);
  localparam int CORN_GAP = P_CORNER - 1;
  logic [2:0] hcnt_r;
  logic [23:0] rcnt_r;
  logic [2:0] first_r;
  logic vref_r;
  int exp_len;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // strobe high run, reference run length, first reference, reference input seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_r <= 3'h0;
      rcnt_r <= 24'h0;
      first_r <= 3'h0;
      vref_r <= 1'b0;
    end else begin
      hcnt_r <= cal_strobe ? hcnt_r + {2'h0, hcnt_r != 3'h7} : 3'h0;
      rcnt_r <= (ref_select != 3'h0) ? rcnt_r + 24'h1 : 24'h0;
      if (ref_select != 3'h0 && rcnt_r == 24'h0) first_r <= ref_select;
      vref_r <= (ref_select == 3'h4) || (vref_r && ref_select != 3'h0);
    end
  end
  // expected length from the references the run used
  assign exp_len = (first_r == 3'h1 || first_r == 3'h2) ? P_SELF :
    (first_r == 3'h5) ? P_SYS_GAIN : vref_r ? P_ONE_OFS : P_SYS_OFS;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_cal_word_high: assert property (ref_select != 3'h0 |-> word_available_n)
    else $error("word offered during calibration");
  a_start_fall: assert property ($rose(cal_busy) |-> !cal_strobe && !$past(cal_strobe))
    else $error("calibration began while strobe high");
  a_short_ignored: assert property ($fell(cal_strobe) && hcnt_r <= 3'h2 && !cal_busy
    |-> ##1 !cal_busy [*6]) else $error("short strobe started a calibration");
  a_long_starts: assert property ($fell(cal_strobe) && hcnt_r >= 3'h4 && !cal_busy
    |-> ##[1:5] $rose(cal_busy)) else $error("valid strobe did not start");
  a_ref_order: assert property (ref_select != $past(ref_select) && ref_select != 3'h0
    && $past(ref_select) != 3'h0 |-> ref_select == 3'h4 && $past(ref_select) inside {3'h1, 3'h2, 3'h3})
    else $error("bad reference sequence");
  a_mid_bipolar: assert property ($past(ref_select) == 3'h0 && ref_select inside {3'h1, 3'h2}
    |-> ref_select == (range_polarity_select ? 3'h2 : 3'h1)) else $error("wrong zero reference");
  a_cal_length: assert property (ref_select == 3'h0 && $past(ref_select) != 3'h0
    |-> rcnt_r + 1 >= exp_len && rcnt_r <= exp_len + 1) else $error("calibration length wrong");
  a_settle_word: assert property (ref_select == 3'h0 && $past(ref_select) != 3'h0 && first_r > 3'h2
    |-> ##[0:2] !word_available_n) else $error("word late after system step");
  a_self_wait: assert property (ref_select == 3'h0 && $past(ref_select) inside {3'h4}
    && first_r inside {3'h1, 3'h2} |-> word_available_n [*8]) else $error("word early after self");
  a_sample_rate: assert property (sample_tick |=> !sample_tick ##255 sample_tick)
    else $error("sample tick spacing");
  a_corner_rate: assert property (corner_tick |=> !corner_tick ##CORN_GAP corner_tick)
    else $error("corner tick spacing");
  a_word_coding: assert property ($past(raw_valid) && !word_available_n && !cal_busy
    && !$past(cal_busy) && $stable(range_polarity_select)
    && range_polarity_select == $past(range_polarity_select, 2)
    && range_polarity_select == $past(range_polarity_select, 3)
    |-> data_word == ($past(raw_result) ^ {range_polarity_select, 15'h0})) else $error("coding wrong");
endmodule
`default_nettype wire

// *** verif/adc_calibration_sequencer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_calibration_sequencer_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic range_polarity_select, raw_valid, rv_d, e;
  logic cal_strobe, sel_a, sel_b, word_available_n, cal_busy, sample_tick, corner_tick;
  logic [15:0] raw_result, raw_d, data_word;
  logic [2:0] ref_select;
  logic [3:0] pol_h;
  int err_count, n_tests;
  // shortened counts, the checker's defaults carry the same values
  localparam int T_SELF = 40, T_SYS = 20, T_ONE = 30, T_SETTLE = 10, T_CORNER = 16;
  acs_cal_seq #(.P_SELF(T_SELF), .P_SYS_OFS(T_SYS), .P_SYS_GAIN(T_SYS), .P_ONE_OFS(T_ONE),
    .P_SETTLE(T_SETTLE), .P_CORNER(T_CORNER)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cal_strobe(cal_strobe), .cal_type_select_a(sel_a),
    .cal_type_select_b(sel_b), .range_polarity_select(range_polarity_select),
    .raw_result(raw_result), .raw_valid(raw_valid), .word_available_n(word_available_n),
    .data_word(data_word), .ref_select(ref_select), .cal_busy(cal_busy),
    .sample_tick(sample_tick), .corner_tick(corner_tick));
  acs_host_model u_host (.pclk(pclk), .cal_strobe(cal_strobe), .cal_type_select_a(sel_a),
    .cal_type_select_b(sel_b));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // strobe a calibration, then check its reference and busy length
  task automatic run_cal(input logic [1:0] sel, input int len, input logic [2:0] ref0);
    int n;
    logic [2:0] fr;
    u_host.pulse(sel, 4 + $urandom_range(2));
    n = 0;
    while (cal_busy !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    fr = 3'h0;
    while (cal_busy === 1'b1 && n < 300) begin
      if (fr == 3'h0) fr = ref_select;
      @(posedge pclk);
      n++;
    end
    check(32'(fr), 32'(ref0));
    check(32'(n >= len + T_SETTLE + 1 && n <= len + T_SETTLE + 4), 32'h1);
    repeat (20) @(posedge pclk);
  endtask
  // ------------------------------------------------------------
  // clock, converter results and reference model of the output word
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    raw_result <= 16'($urandom);
    raw_valid <= ($urandom_range(3) == 0);
    // the word was coded with the pin as it stood three edges earlier
    if (presetn && rv_d && word_available_n === 1'b0 && cal_busy === 1'b0)
      check(32'(data_word), 32'(raw_d ^ {pol_h[2], 15'h0}));
    rv_d <= raw_valid;
    raw_d <= raw_result;
    pol_h <= {pol_h[2:0], range_polarity_select};
  end
  initial begin
    #(20000 * 50);
    err_count++;
    test_done();
  end
  // main sequence
  initial begin
    void'($urandom(71));
    {presetn, psel, penable, pwrite, range_polarity_select, raw_valid, rv_d} = 7'h0;
    {paddr, pwdata, raw_result, raw_d, pol_h} = 76'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(word_available_n), 32'h1);
    u_host.pulse(2'b00, 2);
    repeat (10) @(posedge pclk);
    check(32'(cal_busy), 32'h0);
    run_cal(2'b00, T_SELF, 3'h1);
    range_polarity_select <= 1'b1;
    run_cal(2'b00, T_SELF, 3'h2);
    range_polarity_select <= 1'b0;
    run_cal(2'b11, T_SYS, 3'h3);
    run_cal(2'b01, T_SYS, 3'h5);
    run_cal(2'b10, T_ONE, 3'h3);
    apb(1'b0, 8'h08, 32'h0);
    check(q, 32'h5);
    // status after the one-step run: type 10, done set, word offered
    apb(1'b0, 8'h04, 32'h0);
    check(q, 32'h0000000C);
    apb(1'b1, 8'h04, 32'h8);
    apb(1'b0, 8'h04, 32'h0);
    check(q, 32'h00000004);
    apb(1'b0, 8'h10, 32'h0);
    check(q, 32'h0);
    check(32'(e), 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    check(32'(q[0]), 32'h1);
    repeat (80) @(posedge pclk);
    check(32'(cal_busy), 32'h0);
    test_done();
  end
endmodule
// checker defaults equal the bench's shortened counts
bind acs_cal_seq acs_cal_seq_properties u_props (.pclk(pclk), .presetn(presetn),
  .cal_strobe(cal_strobe), .range_polarity_select(range_polarity_select),
  .raw_result(raw_result), .raw_valid(raw_valid), .word_available_n(word_available_n),
  .data_word(data_word), .ref_select(ref_select), .cal_busy(cal_busy),
  .sample_tick(sample_tick), .corner_tick(corner_tick));
`default_nettype wire
